// ### bench/adc_model.sv
// converter model facing the sequencer's adc port
// assumes the bench supplies value, overflow flag and answer delay
`timescale 1ns/1ns
`default_nettype none
module adc_model (
	input  wire logic        clk_i,
	input  wire logic        start_i,
	input  wire logic [15:0] val_i,
	input  wire logic        ovf_i,
	input  wire logic [3:0]  dly_i,
	output logic             done_o = 1'b0,
	output logic [15:0]      value_o = 16'h0000,
	output logic             ovf_o = 1'b0
);
	int cnt = -1; // cycles to the answer, -1 while idle
	// answer dly_i+1 cycles after start; data held one cycle past done, then
	// scrambled every cycle so a late sample cannot pass by luck
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (start_i)
			cnt <= dly_i;
		else if (cnt > 0)
			cnt <= cnt - 1;
		if (!start_i && cnt == 0) begin
			done_o <= 1'b1;
			value_o <= val_i;
			ovf_o <= ovf_i;
			cnt <= -1;
		end else if (!done_o) begin
			value_o <= ~value_o;
			ovf_o <= ~ovf_o;
		end
	end
endmodule
`default_nettype wire

// ### bench/prox_seq_checker.sv
// port assertions for the proximity measurement sequencer
// assumes it is bound onto every prox_seq instance
`timescale 1ns/1ns
`default_nettype none
module prox_seq_checker #(
	parameter int NCH = 3
) (
	input wire logic           sys_clk_i,
	input wire logic           sys_rst_i,
	input wire logic           cmd_valid_i,
	input wire logic [1:0]     cmd_code_i,
	input wire logic           cmd_ready_o,
	input wire logic           busy_o,
	input wire logic [6:0]     bus_addr_i,
	input wire logic           addr_match_o,
	input wire logic [NCH-1:0] channel_enable_list_i,
	input wire logic           adc_start_o,
	input wire logic           adc_als_o,
	input wire logic           adc_done_i,
	input wire logic           adc_ovf_i,
	input wire logic           ovf_status_o,
	input wire logic           long_int_i,
	input wire logic [7:0]     adc_int_time_o,
	input wire logic           int_clear_i,
	input wire logic           proximity_sensing_int_oe_n_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	wire take_w = cmd_valid_i && cmd_ready_o; // command accepted at this edge
	prox_start_a:
		assert property (take_w && cmd_code_i == 2'h1 && channel_enable_list_i[0]
			|-> ##2 adc_start_o && !adc_als_o) else $error("no start after command");
	als_start_a:
		assert property (take_w && cmd_code_i == 2'h2 |-> ##1 adc_start_o && adc_als_o)
			else $error("no ambient start after command");
	ovf_flag_a:
		assert property (busy_o && adc_done_i && adc_ovf_i |-> ##[1:2] ovf_status_o)
			else $error("overflow not flagged");
	ovf_held_a:
		assert property ($fell(ovf_status_o) |-> $past(take_w && cmd_code_i == 2'h0))
			else $error("overflow flag dropped without no-op");
	int_clear_a:
		assert property ($rose(proximity_sensing_int_oe_n_o) |-> $past(int_clear_i))
			else $error("interrupt released without clear");
	int_cause_a:
		assert property ($fell(proximity_sensing_int_oe_n_o) |-> $past(busy_o)
			|| $past(busy_o, 2)) else $error("interrupt outside a measurement");
	addr_match_a:
		assert property (addr_match_o == (bus_addr_i == 7'h5a || bus_addr_i == 7'h00))
			else $error("address match wrong");
	int_time_a:
		assert property (adc_start_o |-> adc_int_time_o == (long_int_i ? 8'h08 : 8'h01))
			else $error("integration time wrong");
	cover property (take_w && cmd_code_i == 2'h0 && ovf_status_o);
	cover property (adc_done_i && adc_ovf_i);
	cover property ($fell(proximity_sensing_int_oe_n_o));
endmodule
bind prox_seq prox_seq_checker #(.NCH(NCH)) chk (.*);
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the proximity measurement sequencer
// assumes the converter model and checker are compiled before it
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic sys_clk_i = 0, sys_rst_i = 1, cmd_valid_i = 0, auto_en_i = 0, aovf = 0;
	logic led_sel_load_i = 0, int_set_mode_i = 1, high_range_i = 0, long_int_i = 0;
	logic int_clear_i = 0, cmd_ready_o, addr_match_o, adc_start_o, adc_als_o;
	logic adc_high_range_o, adc_done_i, adc_ovf_i, ovf_status_o, busy_o;
	logic proximity_sensing_int_o, proximity_sensing_int_oe_n_o;
	wire         proximity_sensing_int_i;
	logic [1:0]  cmd_code_i = 0;
	logic [2:0]  channel_enable_list_i = 0, thr_en_i = 0, adc_led_o;
	logic [3:0]  adc_cur_o, adly = 0;
	logic [6:0]  bus_addr_i = 0;
	logic [6:0]  adr [4] = '{7'h5a, 7'h00, 7'h5b, 7'h2d};
	logic [7:0]  adc_int_time_o;
	logic [8:0]  led_sel_i = 0;
	logic [11:0] led_cur_i = 0;
	logic [15:0] auto_rate_i = 16'h0003, aval = 0, adc_value_i, als_result_o;
	logic [15:0] res [3]; // modelled result per channel
	logic [31:0] seed = 32'hd81f_0482;
	logic [47:0] thr_i = 0, result_o;
	bit          side [3]; // modelled threshold side, 1 above
	bit          mov, hit, ab; // modelled overflow flag, interrupt cause, side
	int          fail_count, checks_done, cyc;
	// shared interrupt line with pull-up; the design is its only driver
	assign proximity_sensing_int_i = proximity_sensing_int_oe_n_o ? 1'b1 : proximity_sensing_int_o;
	prox_seq dut (.*);
	adc_model adc (.clk_i(sys_clk_i), .start_i(adc_start_o), .val_i(aval), .ovf_i(aovf),
		.dly_i(adly), .done_o(adc_done_i), .value_o(adc_value_i), .ovf_o(adc_ovf_i));
	always #5 sys_clk_i = ~sys_clk_i;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic step(input int n = 1);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic cmd(input logic [1:0] c);
		cmd_valid_i = 1;
		cmd_code_i = c;
		step();
		cmd_valid_i = 0;
	endtask
	task automatic do_reset;
		sys_rst_i = 1;
		step(8);
		sys_rst_i = 0;
		res = '{default: 0};
		side = '{default: 0};
		mov = 0;
		check(result_o, 48'h0);
		check(proximity_sensing_int_oe_n_o, 1'b1);
	endtask
	task automatic load(input logic [8:0] m);
		led_sel_i = m;
		led_sel_load_i = 1;
		step();
		led_sel_load_i = 0;
	endtask
	// one measurement set, by command or by the interval timer, against the model
	task automatic prox_set(input bit iss, input logic [2:0] lst, input logic [8:0] msk,
		input logic [2:0] ovm);
		int n;
		hit = 0;
		channel_enable_list_i = lst;
		seed = lfsr(seed);
		led_cur_i = seed[11:0];
		if (iss)
			cmd(2'h1);
		for (n = 0; n < 60 && !busy_o; n++) step();
		auto_en_i = 0;
		for (int ch = 0; ch < 3; ch++) begin
			if (lst[ch]) begin
				for (n = 0; n < 60 && !adc_start_o; n++) step();
				check(adc_led_o, msk[3*ch +: 3]);
				check(adc_cur_o, led_cur_i[4*ch +: 4]);
				check(adc_high_range_o, high_range_i);
				check(adc_int_time_o, long_int_i ? 8'h08 : 8'h01);
				check(adc_als_o, 1'b0);
				check(cmd_ready_o, 1'b0);
				seed = lfsr(seed);
				aval = seed[15:0];
				aovf = ovm[ch];
				adly = seed[19:16];
				res[ch] = aovf ? 16'hffff : aval;
				mov |= aovf;
				ab = aovf || aval > thr_i[16*ch +: 16];
				if (thr_en_i[ch] && ab != side[ch])
					hit = 1;
				side[ch] = ab;
				step();
				if (ch == 0)
					cmd(2'h2); // must be ignored while busy
			end
		end
		for (n = 0; n < 60 && busy_o !== 1'b0; n++) step();
		step();
		for (int ch = 0; ch < 3; ch++) check(result_o[16*ch +: 16], res[ch]);
		check(ovf_status_o, mov);
		check(proximity_sensing_int_i, !(int_set_mode_i || hit));
		int_clear_i = 1;
		step();
		int_clear_i = 0;
	endtask
	initial begin
		step(8);
		sys_rst_i = 0;
		foreach (adr[i]) begin
			bus_addr_i = adr[i];
			#1 check(addr_match_o, adr[i] == 7'h5a || adr[i] == 7'h00);
		end
		prox_set(1, 3'b111, 9'h111, 3'b000);
		$display("test defaults done");
		load(9'h054);
		prox_set(1, 3'b101, 9'h054, 3'b100);
		$display("test reversed overflow done");
		load(9'h1ff);
		long_int_i = 1;
		high_range_i = 1;
		prox_set(1, 3'b111, 9'h1ff, 3'b000);
		cmd(2'h0);
		step();
		check(ovf_status_o, 1'b0);
		$display("test overflow clear done");
		do_reset();
		int_set_mode_i = 0;
		thr_en_i = 3'b111;
		thr_i = 48'h8000_8000_8000;
		repeat (4) prox_set(1, 3'b111, 9'h111, 3'b000);
		prox_set(1, 3'b111, 9'h111, 3'b010);
		$display("test thresholds done");
		cmd(2'h2);
		for (int n = 0; n < 60 && !adc_start_o; n++) step();
		check(adc_als_o, 1'b1);
		seed = lfsr(seed);
		aval = seed[15:0];
		aovf = 0;
		step();
		for (int n = 0; n < 60 && busy_o !== 1'b0; n++) step();
		step();
		check(als_result_o, aval);
		$display("test ambient done");
		int_set_mode_i = 1;
		auto_en_i = 1;
		prox_set(0, 3'b011, 9'h111, 3'b000);
		$display("test autonomous done");
		report_and_stop();
	end
endmodule
`default_nettype wire

// ### rtl/interval_timer.sv
// periodic tick divider for autonomous measurement
// assumes one clock; emits a one-cycle tick every rate_i+1 cycles
`timescale 1ns/1ns
`default_nettype none

module interval_timer #(
	parameter int W = 16
) (
	input  wire logic         sys_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         run_i,
	input  wire logic [W-1:0] rate_i,
	output logic              tick_o
);

	logic [W-1:0] cnt_r;   // down counter
	logic [W-1:0] cnt_nxt; // next count
	logic         tick_r;  // registered tick
	logic         tick_nxt;

	// reload on zero; held idle when not running so first tick is a full interval
	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (!run_i) begin
			cnt_nxt = rate_i;
		end else if (cnt_r == '0) begin
			cnt_nxt  = rate_i;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// registers only
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_o = tick_r;

endmodule

`default_nettype wire

// ### rtl/prox_seq.sv
// proximity measurement sequencer: commands, channel loop, thresholds, overflow
// assumes an external adc answering start with done plus value and overflow flag
// Operation
// RULE1: start measurement on host command
// RULE2: autonomous repeat; interrupt per sample or threshold
// RULE3: up to three channels, gated by list
// RULE4: per-channel led selection, any combination
// RULE5: reset default is one led per channel
// RULE6: optional per-channel threshold compare
// RULE7: threshold mode interrupts only on crossing
// RULE8: interrupt after full measurement set
// RULE9: independent led current, changeable any time
// RULE10: overflow writes all ones, flags status
// RULE11: overflow not sticky in results
// RULE12: status overflow held until no-op command
// RULE13: commands still accepted during overflow
// RULE14: host chooses low or high range
// RULE15: selectable longer integration time
// RULE16: active-low open-drain shared interrupt line
// RULE17: answer fixed address and general call
// RULE18: results sixteen bit, all ones overflow
// RULE19: channels in order; evaluate after write
`timescale 1ns/1ns
`default_nettype none
`include "prox_seq_defs.svh"

module prox_seq #(
	parameter int NCH    = `PS_NUM_CH,
	parameter int RATE_W = 16
) (
	input  wire logic                          sys_clk_i,
	input  wire logic                          sys_rst_i,
	// host command strobe
	input  wire logic                          cmd_valid_i,
	input  wire logic [1:0]                    cmd_code_i,
	output logic                               cmd_ready_o,
	// bus address match
	input  wire logic [6:0]                    bus_addr_i,
	output logic                               addr_match_o,
	// configuration
	input  wire logic                          auto_en_i,
	input  wire logic [RATE_W-1:0]             auto_rate_i,
	input  wire logic [NCH-1:0]                channel_enable_list_i,
	input  wire logic [NCH*`PS_LED_W-1:0]      led_sel_i,
	input  wire logic                          led_sel_load_i,
	input  wire logic [NCH*`PS_CUR_W-1:0]      led_cur_i,
	input  wire logic [NCH-1:0]                thr_en_i,
	input  wire logic [NCH*`PS_RESULT_W-1:0]   thr_i,
	input  wire logic                          int_set_mode_i,
	input  wire logic                          high_range_i,
	input  wire logic                          long_int_i,
	// adc
	output logic                               adc_start_o,
	output logic                               adc_als_o,
	output logic [`PS_LED_W-1:0]               adc_led_o,
	output logic [`PS_CUR_W-1:0]               adc_cur_o,
	output logic                               adc_high_range_o,
	output logic [7:0]                         adc_int_time_o,
	input  wire logic                          adc_done_i,
	input  wire logic [`PS_RESULT_W-1:0]       adc_value_i,
	input  wire logic                          adc_ovf_i,
	// results and status
	output logic [NCH*`PS_RESULT_W-1:0]        result_o,
	output logic [`PS_RESULT_W-1:0]            als_result_o,
	output logic                               ovf_status_o,
	output logic                               busy_o,
	// open-drain interrupt pin
	input  wire logic                          proximity_sensing_int_i,
	output logic                               proximity_sensing_int_o,
	output logic                               proximity_sensing_int_oe_n_o,
	input  wire logic                          int_clear_i
);

	// behaviour in brief, for whoever picks this block up next:
	// - the sequencer sits in idle until a host command or an interval tick
	// - a no-op command only clears the held overflow status, nothing else
	// - a proximity command or tick latches the channel list for the whole set
	// - the list is latched so a host rewrite mid-set cannot skip or repeat
	//   a channel; the cost is that a new list only applies to the next set
	// - channels run strictly in order 0, 1, 2, disabled ones are skipped
	// - each channel pulses adc start once, then waits for the done strobe
	// - the value and overflow flag are read one cycle after done, so the
	//   converter must hold them for that cycle; this keeps the compare off
	//   the done path at the price of one cycle per channel
	// - an overflowed conversion stores all ones, a good one stores the value
	// - overflow status is a held flag; only the no-op command clears it
	// - commands keep being accepted while that flag is set
	// - threshold mode tracks the last side of the threshold per channel
	// - an interrupt is raised only when that side changes, overflow counts
	//   as above, and the side after reset is below
	// - set mode raises one interrupt when the last channel of a set is done
	// - set mode and threshold mode are exclusive; set mode wins
	// - a pending interrupt is held until the host pulses the clear input
	// - when a clear and a new interrupt fall in one cycle, the new one wins,
	//   so an event is never lost to a late clear
	// - led masks are registered and reloaded only by the load strobe
	// - led currents are read live, so the host may change them at any time;
	//   a change during a conversion reaches the converter at once
	// - range and integration time are plain levels passed to the converter
	// - the ambient measurement uses its own state and its own result
	// - an ambient overflow also sets the held status flag
	// - the interrupt pin is open drain: the data output is tied low and only
	//   the active-low enable moves, so other sources may share the line
	// - the address match is a pure decode of the address seen on the bus
	// limitations:
	// - a tick that arrives while a set or ambient run is busy is dropped;
	//   the interval should be longer than one full set
	// - a no-op and a tick in the same idle cycle: the no-op is served and
	//   the tick is dropped
	// - while idle the channel index may point past the last channel; the
	//   clamp below keeps the converter outputs defined in that case

	// channel index clamped into range so idle outputs never read past the vectors
	function automatic logic [1:0] ch_sel(input logic [1:0] c);
		return (c >= 2'(NCH)) ? 2'(NCH - 1) : c;
	endfunction

	// index of the next enabled channel at or after start, NCH when none
	function automatic logic [1:0] next_ch(input logic [NCH-1:0] en, input logic [1:0] start);
		logic [1:0] r;
		r = 2'(NCH);
		for (int k = NCH - 1; k >= 0; k--) begin
			if (en[k] && (2'(k) >= start))
				r = 2'(k);
		end
		return r;
	endfunction

	prox_seq_pkg::seq_state_e st_r, st_nxt;     // sequencer state
	logic [1:0]                ch_r, ch_nxt;    // current channel
	logic [NCH-1:0]            list_r, list_nxt; // list latched per set
	logic [NCH*`PS_LED_W-1:0]  led_r, led_nxt;   // led selection per channel
	logic [NCH*`PS_RESULT_W-1:0] res_r, res_nxt; // results
	logic [`PS_RESULT_W-1:0]   als_r, als_nxt;   // ambient result
	logic [NCH-1:0]            above_r, above_nxt; // last side of threshold
	logic                      ovf_r, ovf_nxt;   // held overflow status
	logic                      irq_r, irq_nxt;   // pending interrupt
	logic                      start_r, start_nxt; // adc start pulse
	logic                      als_mode_r, als_mode_nxt;
	logic                      tick;             // autonomous interval tick
	logic                      above_now;

	interval_timer #(.W(RATE_W)) u_timer (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (auto_en_i),                     // RULE2
		.rate_i    (auto_rate_i),
		.tick_o    (tick)
	);

	// commands are taken in idle regardless of overflow status
	assign cmd_ready_o  = (st_r == prox_seq_pkg::ST_IDLE); // RULE13
	assign addr_match_o = (bus_addr_i == `PS_I2C_ADDR) || (bus_addr_i == `PS_I2C_GCALL); // RULE17
	assign busy_o       = (st_r != prox_seq_pkg::ST_IDLE);
	assign above_now    = adc_value_i > thr_i[ch_sel(ch_r)*`PS_RESULT_W +: `PS_RESULT_W];

	// sequencer next-state and datapath
	always_comb begin
		st_nxt       = st_r;
		ch_nxt       = ch_r;
		list_nxt     = list_r;
		led_nxt      = led_r;
		res_nxt      = res_r;
		als_nxt      = als_r;
		above_nxt    = above_r;
		ovf_nxt      = ovf_r;
		irq_nxt      = irq_r;
		start_nxt    = 1'b0;
		als_mode_nxt = als_mode_r;
		if (led_sel_load_i)
			led_nxt = led_sel_i;                     // RULE4
		if (int_clear_i)
			irq_nxt = 1'b0;
		case (st_r)
			prox_seq_pkg::ST_IDLE: begin
				if (cmd_valid_i && cmd_code_i == `PS_CMD_NOP) begin
					ovf_nxt = 1'b0;                  // RULE12
				end else if ((cmd_valid_i && cmd_code_i == `PS_CMD_PS) || tick) begin // RULE1 RULE2
					list_nxt = channel_enable_list_i; // RULE3
					ch_nxt   = next_ch(channel_enable_list_i, 2'd0); // RULE19
					st_nxt   = prox_seq_pkg::ST_NEXT;
				end else if (cmd_valid_i && cmd_code_i == `PS_CMD_ALS) begin // RULE1
					als_mode_nxt = 1'b1;
					start_nxt    = 1'b1;
					st_nxt       = prox_seq_pkg::ST_ALS;
				end
			end
			prox_seq_pkg::ST_NEXT: begin
				// no channel left ends the set
				if (ch_r >= 2'(NCH)) begin
					if (int_set_mode_i == `PS_IMODE_SET)
						irq_nxt = 1'b1;              // RULE8
					st_nxt = prox_seq_pkg::ST_IDLE;
				end else begin
					als_mode_nxt = 1'b0;
					start_nxt    = 1'b1;
					st_nxt       = prox_seq_pkg::ST_WAIT;
				end
			end
			prox_seq_pkg::ST_WAIT: begin
				if (adc_done_i)
					st_nxt = prox_seq_pkg::ST_STORE;
			end
			prox_seq_pkg::ST_STORE: begin
				// overflow forces all ones; a good reading restores normal data
				if (adc_ovf_i) begin
					res_nxt[ch_r*`PS_RESULT_W +: `PS_RESULT_W] = `PS_OVF_VALUE; // RULE10 RULE18
					ovf_nxt = 1'b1;                  // RULE10
				end else begin
					res_nxt[ch_r*`PS_RESULT_W +: `PS_RESULT_W] = adc_value_i; // RULE11
				end
				// crossing check after the write, only in threshold mode
				if (thr_en_i[ch_r] && int_set_mode_i != `PS_IMODE_SET) begin // RULE6
					above_nxt[ch_r] = above_now || adc_ovf_i;
					if (above_r[ch_r] != (above_now || adc_ovf_i))
						irq_nxt = 1'b1;              // RULE7
				end
				ch_nxt = next_ch(list_r, ch_r + 2'd1); // RULE19
				st_nxt = prox_seq_pkg::ST_NEXT;
			end
			prox_seq_pkg::ST_ALS: begin
				if (adc_done_i) begin
					als_nxt = adc_ovf_i ? `PS_OVF_VALUE : adc_value_i;
					if (adc_ovf_i)
						ovf_nxt = 1'b1;
					st_nxt = prox_seq_pkg::ST_IDLE;
				end
			end
			default: st_nxt = prox_seq_pkg::ST_IDLE;
		endcase
	end

	// state registers
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			st_r       <= prox_seq_pkg::ST_IDLE;
			ch_r       <= 2'd0;
			list_r     <= '0;
			led_r      <= {`PS_LED_DEF2, `PS_LED_DEF1, `PS_LED_DEF0}; // RULE5
			res_r      <= '0;
			als_r      <= '0;
			above_r    <= '0;
			ovf_r      <= 1'b0;
			irq_r      <= 1'b0;
			start_r    <= 1'b0;
			als_mode_r <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			ch_r       <= ch_nxt;
			list_r     <= list_nxt;
			led_r      <= led_nxt;
			res_r      <= res_nxt;
			als_r      <= als_nxt;
			above_r    <= above_nxt;
			ovf_r      <= ovf_nxt;
			irq_r      <= irq_nxt;
			start_r    <= start_nxt;
			als_mode_r <= als_mode_nxt;
		end
	end

	// adc drive; current read live so the host may change it at any time
	assign adc_start_o      = start_r;
	assign adc_als_o        = als_mode_r;
	assign adc_led_o        = als_mode_r ? '0 : led_r[ch_sel(ch_r)*`PS_LED_W +: `PS_LED_W];
	assign adc_cur_o        = led_cur_i[ch_sel(ch_r)*`PS_CUR_W +: `PS_CUR_W]; // RULE9
	assign adc_high_range_o = high_range_i;     // RULE14
	assign adc_int_time_o   = long_int_i ? `PS_INT_LONG : `PS_INT_NORM; // RULE15

	assign result_o     = res_r;
	assign als_result_o = als_r;
	assign ovf_status_o = ovf_r;

	// open drain: drive low only, enable active low while driving
	assign proximity_sensing_int_o      = 1'b0;     // RULE16
	assign proximity_sensing_int_oe_n_o = ~irq_r;   // RULE16

endmodule

`default_nettype wire

// ### rtl/prox_seq_defs.svh
// constants for the proximity measurement sequencer
// assumes inclusion by bare name from any design or bench file
`ifndef PROX_SEQ_DEFS_SVH
`define PROX_SEQ_DEFS_SVH

`define PS_NUM_CH         3
`define PS_RESULT_W       16
`define PS_OVF_VALUE      16'hFFFF
`define PS_LED_W          3
`define PS_CUR_W          4
`define PS_LED_DEF0       3'h1
`define PS_LED_DEF1       3'h2
`define PS_LED_DEF2       3'h4
`define PS_I2C_ADDR       7'h5A
`define PS_I2C_GCALL      7'h00
`define PS_INT_NORM       8'h01
`define PS_INT_LONG       8'h08
`define PS_CMD_NOP        2'h0
`define PS_CMD_PS         2'h1
`define PS_CMD_ALS        2'h2
`define PS_IMODE_SET      1'b1

`endif

// ### rtl/prox_seq_pkg.sv
// shared types for the proximity measurement sequencer
// assumes prox_seq_defs.svh is compiled alongside
package prox_seq_pkg;

	// sequencer states, gray coded along idle-start-wait-store-next
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_WAIT  = 3'b011,
		ST_STORE = 3'b010,
		ST_NEXT  = 3'b110,
		ST_ALS   = 3'b111
	} seq_state_e;

	// host command codes
	typedef logic [1:0] cmd_t;

endpackage
